// ===== adcsq_ctrl.sv
// Purpose: control and sequencing of a four-input successive-approximation converter
// Assumes: Avalon-MM slave, byte addresses; comparator answers in the same cycle
// Notes: one state per ref_clk_i cycle; analog front end sits outside
//
// Register access over Avalon-MM and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_defs.svh"
module adcsq_ctrl
	import adcsq_pkg::*;
#(
	parameter int ADDR_W = 5
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic [ADDR_W-1:0] address_i,
	input wire logic read_i,
	input wire logic write_i,
	input wire logic [3:0] byteenable_i,
	input wire logic [31:0] writedata_i,
	output logic [31:0] readdata_o,
	output logic waitrequest_o,
	input wire logic cmp_above_i,
	input wire logic standby_i,
	input wire logic dma_ack_i,
	output logic [1:0] input_select_o,
	output logic sample_o,
	output logic [9:0] trial_code_o,
	output logic conversion_end_interrupt_o,
	output logic dma_req_o
);
	initial begin
		if (ADDR_W < 5) begin
			$error("adcsq_ctrl: ADDR_W must be at least 5");
		end
	end

	////////////////////////////////////////////////////////////////////////
	// timing lookup by clock select; 11 behaves as divide 16
	function automatic logic [9:0] td_min(input logic [1:0] c);
		td_min = (c == 2'h0) ? `ADCSQ_TD_DIV4 : (c == 2'h1) ? `ADCSQ_TD_DIV8 : `ADCSQ_TD_DIV16;
	endfunction
	function automatic logic [9:0] spl_len(input logic [1:0] c);
		spl_len = (c == 2'h0) ? `ADCSQ_SPL_DIV4 : (c == 2'h1) ? `ADCSQ_SPL_DIV8 : `ADCSQ_SPL_DIV16;
	endfunction
	function automatic logic [9:0] conv_len(input logic [1:0] c);
		conv_len = (c == 2'h0) ? `ADCSQ_CONV_DIV4 : (c == 2'h1) ? `ADCSQ_CONV_DIV8 : `ADCSQ_CONV_DIV16;
	endfunction
	function automatic logic [9:0] fix_len(input logic [1:0] c);
		fix_len = (c == 2'h0) ? `ADCSQ_FIX_DIV4 : (c == 2'h1) ? `ADCSQ_FIX_DIV8 : `ADCSQ_FIX_DIV16;
	endfunction

	adcsq_state_s s_ff;
	adcsq_state_s nxt_s;
	logic req;
	logic acc;
	logic wr_csr;
	logic rd_csr;
	logic busy;
	logic last_ch;
	logic done;
	logic keep;
	logic [9:0] res;
	logic [9:0] wbit;
	logic pass_end;
	logic flag_set;

	////////////////////////////////////////////////////////////////////////
	// bus side: one wait cycle, then the access is taken
	assign req = read_i | write_i;
	assign waitrequest_o = req & ~s_ff.ack;
	assign acc = req & s_ff.ack;
	assign wr_csr = acc & write_i & (address_i[4:0] == `ADCSQ_OFS_CSR);
	assign rd_csr = acc & read_i & (address_i[4:0] == `ADCSQ_OFS_CSR);
	assign busy = s_ff.st != ADCSQ_IDLE;
	// group modes end at the selected channel too, counting up from 0
	assign last_ch = s_ff.cur == s_ff.csr.ch;
	assign done = (s_ff.st == ADCSQ_CONV) && (s_ff.cnt == 10'h001);
	// comparator decision on the bit now under trial
	assign wbit = (s_ff.cnt <= 10'h00a && s_ff.cnt != 10'h000) ? (10'h001 << (s_ff.cnt - 10'h001)) : 10'h000;
	assign keep = cmp_above_i;
	assign res = keep ? s_ff.trial : (s_ff.trial & ~wbit);
	assign pass_end = done & last_ch;
	assign flag_set = pass_end & s_ff.csr.start;

	////////////////////////////////////////////////////////////////////////
	// next-state logic for registers, sequencer and bus answer
	always_comb begin
		nxt_s = s_ff;
		nxt_s.phase = s_ff.phase + 2'h1;
		nxt_s.ack = req & ~s_ff.ack;
		// read data latched in the wait cycle; unmapped reads give zero
		if (req && !s_ff.ack) begin
			nxt_s.rdata = 32'h0000_0000;
			if (address_i[4:0] == `ADCSQ_OFS_CSR) begin
				nxt_s.rdata[15:0] = {s_ff.csr.flag, s_ff.csr.ie, s_ff.csr.start, s_ff.csr.dma_sel, 4'h0,
					s_ff.csr.cks, s_ff.csr.mode, 2'h0, s_ff.csr.ch};
			end else if (address_i[4:0] >= `ADCSQ_OFS_DATA0 && address_i[4:0] <= `ADCSQ_OFS_DATA3
				&& address_i[1:0] == 2'h0) begin
				nxt_s.rdata[9:0] = s_ff.data[address_i[3:2] - 2'h1];
			end else begin
				nxt_s.rdata = 32'h0000_0000;
			end
		end
		// a read that sees the flag set arms the clear
		if (rd_csr && s_ff.csr.flag) begin
			nxt_s.armed = 1'b1;
		end
		// settings and start written together in one access
		if (wr_csr && byteenable_i[0]) begin
			nxt_s.csr.cks = writedata_i[`ADCSQ_B_CKS];
			nxt_s.csr.mode = adcsq_mode_e'(writedata_i[`ADCSQ_B_MODE]);
			nxt_s.csr.ch = writedata_i[`ADCSQ_B_CH];
		end
		if (wr_csr && byteenable_i[1]) begin
			nxt_s.csr.ie = writedata_i[`ADCSQ_B_IE];
			nxt_s.csr.dma_sel = writedata_i[`ADCSQ_B_DMASEL];
			nxt_s.csr.start = writedata_i[`ADCSQ_B_START];
			// writing one to the flag does nothing
			if (!writedata_i[`ADCSQ_B_FLAG] && s_ff.armed) begin
				nxt_s.csr.flag = 1'b0;
				nxt_s.armed = 1'b0;
			end
		end
		if (dma_ack_i && s_ff.csr.dma_sel) begin
			nxt_s.csr.flag = 1'b0;
		end
		// sequencer; lowest channel first in group modes
		case (s_ff.st)
			ADCSQ_IDLE: begin
				if (nxt_s.csr.start && !s_ff.csr.start) begin
					nxt_s.st = ADCSQ_DELAY;
					// delay stretches with the divider phase of the write
					nxt_s.cnt = td_min(nxt_s.csr.cks) + {8'h00, ~s_ff.phase};
					nxt_s.cur = (nxt_s.csr.mode[1]) ? 2'h0 : nxt_s.csr.ch;
				end
			end
			ADCSQ_DELAY: begin
				nxt_s.cnt = s_ff.cnt - 10'h001;
				if (s_ff.cnt == 10'h001) begin
					nxt_s.st = ADCSQ_SAMPLE;
					nxt_s.cnt = spl_len(s_ff.csr.cks);
				end
			end
			ADCSQ_SAMPLE: begin
				nxt_s.cnt = s_ff.cnt - 10'h001;
				if (s_ff.cnt == 10'h001) begin
					nxt_s.st = ADCSQ_CONV;
					nxt_s.cnt = conv_len(s_ff.csr.cks);
					nxt_s.trial = 10'h000;
				end
			end
			ADCSQ_CONV: begin
				nxt_s.cnt = s_ff.cnt - 10'h001;
				// one bit decided per cycle over the last ten cycles
				if (s_ff.cnt == 10'h00b) begin
					nxt_s.trial = 10'h200;
				end else if (wbit != 10'h000) begin
					nxt_s.trial = res | (wbit >> 1);
				end
				if (done) begin
					nxt_s.data[s_ff.cur] = res;
					if (!last_ch) begin
						nxt_s.cur = s_ff.cur + 2'h1;
						nxt_s.st = ADCSQ_SAMPLE;
						nxt_s.cnt = spl_len(s_ff.csr.cks);
					end else if (s_ff.csr.mode == ADCSQ_SCAN) begin
						nxt_s.cur = 2'h0;
						nxt_s.st = ADCSQ_SAMPLE;
						nxt_s.cnt = spl_len(s_ff.csr.cks);
					end else begin
						nxt_s.st = ADCSQ_IDLE;
						nxt_s.csr.start = 1'b0;
					end
				end
			end
			default: begin
				nxt_s.st = ADCSQ_IDLE;
			end
		endcase
		// later group conversions: sampling plus rest of fixed total
		if (s_ff.st == ADCSQ_SAMPLE && s_ff.cnt == 10'h001 && (s_ff.cur != 2'h0 || s_ff.csr.start != nxt_s.csr.start
			|| s_ff.trial != 10'h000)) begin
			nxt_s.cnt = conv_len(s_ff.csr.cks);
		end
		if (s_ff.st == ADCSQ_SAMPLE && s_ff.cnt == 10'h001 && s_ff.csr.mode[1] && s_ff.trial == 10'h3ff) begin
			nxt_s.cnt = fix_len(s_ff.csr.cks) - spl_len(s_ff.csr.cks);
		end
		if (s_ff.st == ADCSQ_CONV && done && !(!last_ch || s_ff.csr.mode == ADCSQ_SCAN)) begin
			nxt_s.trial = 10'h000;
		end else if (s_ff.st == ADCSQ_CONV && done) begin
			// marks the following conversion as a later one of the group
			nxt_s.trial = 10'h3ff;
		end
		// software clear or standby stops any activity; no result stored, except in the done cycle that ends a non-scan pass
		if (standby_i) begin
			nxt_s.csr.start = 1'b0;
		end
		if (busy && !nxt_s.csr.start && !(done && s_ff.csr.mode != ADCSQ_SCAN && last_ch)) begin
			nxt_s.st = ADCSQ_IDLE;
			nxt_s.data = s_ff.data;
			nxt_s.trial = 10'h000;
		end
		// hardware set beats any clear in the same cycle
		if (flag_set) begin
			nxt_s.csr.flag = 1'b1;
		end
		if (!nxt_s.csr.flag) begin
			nxt_s.armed = 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// state register
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			s_ff <= '0;
			s_ff.csr.cks <= `ADCSQ_RST_CKS;
		end else begin
			s_ff <= nxt_s;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// outputs; request routed to interrupt or to DMA
	assign readdata_o = s_ff.rdata;
	assign input_select_o = s_ff.cur;
	assign sample_o = s_ff.st == ADCSQ_SAMPLE;
	assign trial_code_o = (s_ff.st == ADCSQ_CONV && s_ff.cnt <= 10'h00a) ? s_ff.trial : 10'h000;
	assign conversion_end_interrupt_o = s_ff.csr.flag & s_ff.csr.ie & ~s_ff.csr.dma_sel;
	assign dma_req_o = s_ff.csr.flag & s_ff.csr.ie & s_ff.csr.dma_sel;

	////////////////////////////////////////////////////////////////////////
	// helper: cycles spent in the current state
	logic [9:0] dwell_ff;
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			dwell_ff <= 10'h000;
		end else if (nxt_s.st != s_ff.st) begin
			dwell_ff <= 10'h000;
		end else begin
			dwell_ff <= dwell_ff + 10'h001;
		end
	end

	default clocking @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	a_single_start_clear: assert property (pass_end && s_ff.csr.mode == ADCSQ_SINGLE && !standby_i
		|=> !s_ff.csr.start && s_ff.st == ADCSQ_IDLE) else $error("start not cleared after single");
	a_flag_on_end: assert property (flag_set |=> s_ff.csr.flag) else $error("end flag not set");
	a_abort_to_idle: assert property (busy && wr_csr && byteenable_i[1] && !writedata_i[`ADCSQ_B_START]
		|=> s_ff.st == ADCSQ_IDLE) else $error("abort did not idle");
	a_abort_keeps_data: assert property (busy && standby_i |=> $stable(s_ff.data))
		else $error("aborted result stored");
	a_scan_keeps_start: assert property (pass_end && s_ff.csr.mode == ADCSQ_SCAN && !standby_i && !wr_csr
		|=> s_ff.csr.start && s_ff.st == ADCSQ_SAMPLE && s_ff.cur == 2'h0) else $error("scan stopped");
	a_delay_length: assert property (s_ff.st == ADCSQ_DELAY && nxt_s.st == ADCSQ_SAMPLE
		|-> dwell_ff + 10'h001 >= td_min(s_ff.csr.cks) && dwell_ff <= td_min(s_ff.csr.cks) + 10'h002)
		else $error("start delay out of range");
	a_sample_length: assert property (s_ff.st == ADCSQ_SAMPLE && nxt_s.st == ADCSQ_CONV
		|-> dwell_ff + 10'h001 == spl_len(s_ff.csr.cks)) else $error("sampling time wrong");
	a_group_ascend: assert property (done && !last_ch && s_ff.csr.start && !standby_i && !wr_csr
		|=> s_ff.cur == $past(s_ff.cur) + 2'h1) else $error("channel order wrong");
	a_flag_clear_seq: assert property ($fell(s_ff.csr.flag) |-> $past(s_ff.armed) || $past(dma_ack_i))
		else $error("flag cleared without read");
	a_bus_one_wait: assert property (req && waitrequest_o && $stable(address_i) |=> !waitrequest_o)
		else $error("bus wait too long");

	c_single_done: cover property (pass_end && s_ff.csr.mode == ADCSQ_SINGLE);
	c_multi_done: cover property (pass_end && s_ff.csr.mode == ADCSQ_MULTI && s_ff.csr.ch == 2'h3);
	c_scan_pass: cover property (pass_end && s_ff.csr.mode == ADCSQ_SCAN);
	c_abort: cover property (busy && wr_csr && !writedata_i[`ADCSQ_B_START]);
endmodule
`default_nettype wire

// ===== adcsq_defs.svh
// Purpose: offsets, field positions, reset values and timing counts of the sequencer
// Assumes: one peripheral clock state equals one ref_clk_i cycle
// Notes: the counts are in states; the state period is given by ADCSQ_STATE_NS
`ifndef ADCSQ_DEFS_SVH
`define ADCSQ_DEFS_SVH
`define ADCSQ_STATE_NS 40
// byte offsets on the register bus
`define ADCSQ_OFS_CSR 5'h00
`define ADCSQ_OFS_DATA0 5'h04
`define ADCSQ_OFS_DATA3 5'h10
// control/status field positions
`define ADCSQ_B_FLAG 15
`define ADCSQ_B_IE 14
`define ADCSQ_B_START 13
`define ADCSQ_B_DMASEL 12
`define ADCSQ_B_CKS 7:6
`define ADCSQ_B_MODE 5:4
`define ADCSQ_B_CH 1:0
`define ADCSQ_RST_CKS 2'h1
// start delay minimum per clock select, in states
`define ADCSQ_TD_DIV4 10'h006
`define ADCSQ_TD_DIV8 10'h00a
`define ADCSQ_TD_DIV16 10'h012
// input sampling time, in states
`define ADCSQ_SPL_DIV4 10'h021
`define ADCSQ_SPL_DIV8 10'h041
`define ADCSQ_SPL_DIV16 10'h081
// single-mode total maximum (151, 285, 545) less delay max and sampling
`define ADCSQ_CONV_DIV4 10'h06d
`define ADCSQ_CONV_DIV8 10'h0cf
`define ADCSQ_CONV_DIV16 10'h18b
// later conversions in a group: fixed totals 128, 256, 512
`define ADCSQ_FIX_DIV4 10'h080
`define ADCSQ_FIX_DIV8 10'h100
`define ADCSQ_FIX_DIV16 10'h200
`endif

// ===== adcsq_pkg.sv
// Purpose: types shared by the converter sequencer
// Assumes: four inputs, 10-bit results
// Notes: all state of the control block but the dwell_ff helper counter is one packed struct
package adcsq_pkg;
	typedef enum logic [1:0] {
		ADCSQ_IDLE = 2'b00,
		ADCSQ_DELAY = 2'b01,
		ADCSQ_SAMPLE = 2'b10,
		ADCSQ_CONV = 2'b11
	} adcsq_state_e;
	typedef enum logic [1:0] {
		ADCSQ_SINGLE = 2'b00,
		ADCSQ_BADMODE = 2'b01,
		ADCSQ_MULTI = 2'b10,
		ADCSQ_SCAN = 2'b11
	} adcsq_mode_e;
	typedef struct packed {
		logic flag;
		logic ie;
		logic start;
		logic dma_sel;
		logic [1:0] cks;
		adcsq_mode_e mode;
		logic [1:0] ch;
	} adcsq_csr_s;
	typedef struct packed {
		adcsq_csr_s csr;
		logic armed;
		adcsq_state_e st;
		logic [9:0] cnt;
		logic [1:0] cur;
		logic [9:0] trial;
		logic [3:0][9:0] data;
		logic [1:0] phase;
		logic ack;
		logic [31:0] rdata;
	} adcsq_state_s;
endpackage

// ===== adcsq_afe_model.sv
// Purpose: analog side of the sequencer: four input levels, sample-and-hold, comparator
// Assumes: the bench gives each input level as a 10-bit code
// Notes: compares against the held level, so input changes after sampling do not leak in
`timescale 1ns/10ps
`default_nettype none
module adcsq_afe_model (
	input wire logic ref_clk_i,
	input wire logic [3:0][9:0] level_i,
	input wire logic [1:0] input_select_i,
	input wire logic sample_i,
	input wire logic [9:0] trial_code_i,
	output logic cmp_above_o
);
	logic [9:0] held_ff = 10'h000;
	////////////////////////////////////////////////////////////////
	// follow the selected input while sampling, then hold it
	always_ff @(posedge ref_clk_i) begin
		if (sample_i) begin
			held_ff <= level_i[input_select_i];
		end
	end
	// answers in the same cycle, as a real comparator would
	assign cmp_above_o = (held_ff >= trial_code_i);
endmodule
`default_nettype wire

// ===== tb_adc_sequencer_control.sv
// Purpose: self-checking bench for the converter sequencer
// Assumes: one state per clock; levels drawn from a fixed seed
// Notes: conversion time is measured at the interrupt and dma request outputs
`timescale 1ns/10ps
`default_nettype none
`include "adcsq_defs.svh"
module tb_adc_sequencer_control;
	logic ref_clk_i = 1'b0, rst_i = 1'b1, read_i = 1'b0, write_i = 1'b0, standby_i = 1'b0, dma_ack_i = 1'b0;
	logic [4:0] address_i = 5'h00;
	logic [3:0] byteenable_i = 4'h3;
	logic [31:0] writedata_i = 32'h0000_0000, readdata_o, rq;
	logic waitrequest_o, cmp_above_i, sample_o, irq, dma_req_o, smp_d = 1'b0;
	logic [1:0] input_select_o;
	logic [9:0] trial_code_o, old;
	logic [3:0][9:0] lvl = '0;
	logic [15:0] cur;
	logic [1:0] q[$];
	int seed = 32'h42bb_dffb, fail_count = 0, n_tests = 0, n;
	int t_lo[3] = '{141, 275, 535};
	int t_hi[3] = '{151, 285, 545};
	adcsq_ctrl adcsq_ctrl_inst (.ref_clk_i(ref_clk_i), .rst_i(rst_i), .address_i(address_i), .read_i(read_i),
		.write_i(write_i), .byteenable_i(byteenable_i), .writedata_i(writedata_i), .readdata_o(readdata_o),
		.waitrequest_o(waitrequest_o), .cmp_above_i(cmp_above_i), .standby_i(standby_i), .dma_ack_i(dma_ack_i),
		.input_select_o(input_select_o), .sample_o(sample_o), .trial_code_o(trial_code_o),
		.conversion_end_interrupt_o(irq), .dma_req_o(dma_req_o));
	adcsq_afe_model adcsq_afe_model_inst (.ref_clk_i(ref_clk_i), .level_i(lvl), .input_select_i(input_select_o),
		.sample_i(sample_o), .trial_code_i(trial_code_o), .cmp_above_o(cmp_above_i));
	////////////////////////////////////////////////////////////////
	// 25 MHz clock
	always #20 ref_clk_i = ~ref_clk_i;
	// order in which inputs get sampled
	// mid-cycle look avoids racing the registered outputs at the edge
	always @(negedge ref_clk_i) begin
		if (sample_o === 1'b1 && smp_d === 1'b0) begin
			q.push_back(input_select_o);
		end
		smp_d <= sample_o;
	end
	////////////////////////////////////////////////////////////////
	task automatic bus(input logic we, input logic [4:0] a, input logic [15:0] d);
		logic w;
		@(posedge ref_clk_i);
		address_i <= a;
		writedata_i <= {16'h0000, d};
		write_i <= we;
		read_i <= !we;
		// wait and read data settle before the edge that takes the access
		do begin
			@(negedge ref_clk_i);
			w = waitrequest_o;
			rq = readdata_o;
			@(posedge ref_clk_i);
		end while (w !== 1'b0);
		write_i <= 1'b0;
		read_i <= 1'b0;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			fail_count++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	// control word with flag written as zero
	function automatic logic [15:0] csr(logic ie, logic st, logic dm, logic [1:0] ck, logic [1:0] md, logic [1:0] ch);
		return {1'b0, ie, st, dm, 4'h0, ck, md, 2'b00, ch};
	endfunction
	// settings first with start low, unless one combined write is wanted
	task automatic go(input logic [1:0] ck, md, ch, input logic ie, dm, pre);
		for (int i = 0; i < 4; i++) lvl[i] = 10'($random(seed));
		q.delete();
		cur = csr(ie, 1'b0, dm, ck, md, ch);
		if (pre) bus(1'b1, `ADCSQ_OFS_CSR, cur);
		cur[`ADCSQ_B_START] = 1'b1;
		bus(1'b1, `ADCSQ_OFS_CSR, cur);
	endtask
	// edges from the start write until the end flag lands
	task automatic wt();
		n = 0;
		do begin
			@(negedge ref_clk_i);
			n++;
		end while (irq !== 1'b1 && dma_req_o !== 1'b1);
		n = n - 1;
	endtask
	task automatic rdd(input logic [1:0] c);
		bus(1'b0, `ADCSQ_OFS_DATA0 + {1'b0, c, 2'b00}, 16'h0000);
		chk(rq, {22'h0, lvl[c]});
	endtask
	// zero write alone must not clear; read as one, then zero clears
	task automatic clr(input logic st);
		cur[`ADCSQ_B_START] = st;
		bus(1'b1, `ADCSQ_OFS_CSR, cur);
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk(rq[15:13], {1'b1, cur[`ADCSQ_B_IE], st});
		bus(1'b1, `ADCSQ_OFS_CSR, cur);
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk(rq[15], 1'b0);
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", n_tests, fail_count);
		if (fail_count == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	// watchdog well beyond the expected run length
	initial begin
		repeat (60000) @(posedge ref_clk_i);
		fail_count++;
		test_done();
	end
	initial begin
		repeat (20) @(posedge ref_clk_i);
		rst_i <= 1'b0;
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk(rq, 32'h0000_0040);
		bus(1'b1, 5'h14, 16'hffff);
		bus(1'b0, 5'h14, 16'h0000);
		chk(rq, 32'h0000_0000);
		$display("reset and unmapped done");
		for (int k = 2; k >= 0; k--) begin
			go(k[1:0], 2'b00, 2'($random(seed)), 1'b1, 1'b0, 1'b1);
			wt();
			chk(n >= t_lo[k] && n <= t_hi[k], 1);
			rdd(cur[1:0]);
			chk(q.size(), 1);
			clr(1'b0);
			chk(irq, 1'b0);
			$display("single cks %0d done", k);
		end
		// mode, group and start in one write
		go(2'b00, 2'b10, 2'b11, 1'b1, 1'b0, 1'b0);
		wt();
		chk(n >= 141 + 384 && n <= 151 + 384, 1);
		for (int c = 0; c < 4; c++) rdd(c[1:0]);
		chk({q[0], q[1], q[2], q[3]}, 8'b0001_1011);
		// a status read here would arm the clear, so start is checked after it
		clr(1'b0);
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk(rq[15:13], 3'b010);
		$display("multi done");
		go(2'b00, 2'b11, 2'b01, 1'b1, 1'b0, 1'b1);
		wt();
		chk(n >= 141 + 128 && n <= 151 + 128, 1);
		clr(1'b1);
		wt();
		chk({q[0], q[1], q[2], q[3]}, 8'b0001_0001);
		@(posedge ref_clk_i) standby_i <= 1'b1;
		repeat (2) @(posedge ref_clk_i);
		standby_i <= 1'b0;
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk(rq[13], 1'b0);
		n = q.size();
		repeat (300) @(posedge ref_clk_i);
		chk(q.size(), n);
		$display("scan and standby done");
		go(2'b00, 2'b00, 2'b10, 1'b1, 1'b0, 1'b1);
		old = lvl[2];
		wt();
		rdd(2'b10);
		clr(1'b0);
		lvl[2] = ~old;
		go(2'b00, 2'b00, 2'b10, 1'b1, 1'b0, 1'b1);
		lvl[2] = old;
		repeat (60) @(posedge ref_clk_i);
		cur[`ADCSQ_B_START] = 1'b0;
		bus(1'b1, `ADCSQ_OFS_CSR, cur);
		repeat (200) @(posedge ref_clk_i);
		chk(irq, 1'b0);
		rdd(2'b10);
		$display("abort done");
		go(2'b00, 2'b00, 2'b00, 1'b1, 1'b1, 1'b1);
		wt();
		chk({irq, dma_req_o}, 2'b01);
		@(posedge ref_clk_i) dma_ack_i <= 1'b1;
		@(posedge ref_clk_i) dma_ack_i <= 1'b0;
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk({rq[15], dma_req_o}, 2'b00);
		go(2'b00, 2'b00, 2'b01, 1'b0, 1'b0, 1'b1);
		repeat (160) @(posedge ref_clk_i);
		chk(irq, 1'b0);
		bus(1'b0, `ADCSQ_OFS_CSR, 16'h0000);
		chk(rq[15:13], 3'b100);
		rdd(2'b01);
		$display("dma and enable done");
		test_done();
	end
endmodule
`default_nettype wire
